// ### common/tpr_pkg.sv
// constants shared by the thread profiler ring-buffer engine
// assumes a 32-bit AXI4-Lite register bus and a 64-bit memory port
package tpr_pkg;

  localparam int NUM_EV = 4;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CAP      = 8'h04;
  localparam logic [7:0] ADDR_CB_BASE  = 8'h08;
  localparam logic [7:0] ADDR_BUF_BASE = 8'h0C;
  localparam logic [7:0] ADDR_BUF_SIZE = 8'h10;
  localparam logic [7:0] ADDR_THRESH   = 8'h14;
  localparam logic [7:0] ADDR_HEAD     = 8'h18;
  localparam logic [7:0] ADDR_MISS_LO  = 8'h1C;
  localparam logic [7:0] ADDR_MISS_HI  = 8'h20;
  localparam logic [7:0] ADDR_STATUS   = 8'h24;
  localparam logic [7:0] ADDR_INTV0    = 8'h28;
  localparam logic [7:0] ADDR_INTV_END = 8'h38;

  // control bits
  localparam int CTRL_EN   = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_TS   = 2;
  localparam int CTRL_IRQ  = 3;
  localparam int CTRL_RAND = 4;
  // status bits
  localparam int STAT_IRQ  = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_RUN  = 2;
  // capability bits
  localparam int CAP_WRAP  = 0;

  // control block layout in memory
  localparam logic [31:0] CB_HEAD_OFS = 32'h0000_0000;
  localparam logic [31:0] CB_TAIL_OFS = 32'h0000_0008;
  localparam logic [31:0] CB_MISS_OFS = 32'h0000_0010;

  // record layout: 32 bytes as four 64-bit beats
  localparam int          REC_SHIFT = 5;
  localparam int          BEAT_SHIFT = 3;
  localparam logic [1:0]  LAST_BEAT = 2'h3;

  // reset values and limits
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET     = 32'h0000_0000;
  localparam logic [15:0] BUF_SIZE_RESET = 16'h0100;
  localparam logic [15:0] THRESH_RESET   = 16'h00C0;
  localparam logic [31:0] INTV_RESET     = 32'h0001_0000;
  localparam logic [31:0] RELOAD_MIN     = 32'h0000_0040;
  localparam int          RAND_BITS      = 4;
  localparam logic [15:0] LFSR_SEED      = 16'hACE1;
  localparam logic        WRAP_SUPPORTED = 1'b1;

  // counter 0 counts the value-sample instruction
  localparam int VALUE_EV = 0;
  localparam logic [NUM_EV-1:0][7:0] EV_ID = {8'h04, 8'h03, 8'h02, 8'h01};

  localparam logic [1:0] USER_PRIV   = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### dv/test_tpr_thread_profiler.sv
// self-checking bench for the profiler engine
// assumes tpr_pkg, memory model and checker compiled first
`timescale 1ns/1ps
module test_tpr_thread_profiler;
  logic ref_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, retireValid = 0;
  logic fromLower = 0, mgmt = 0, discard = 0;
  logic awready, wready, bvalid, arready, rvalid, memValid, memWrite;
  logic memReady, thresholdIrq;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, memAddr, rdv;
  logic [1:0]  bresp, rresp, resp, priv = 2'h3;
  logic [3:0]  retireEvents = 0, slow = 0;
  logic [15:0] tailIdx = 0;
  logic [63:0] ts = 0, memWdata, memRdata, rec [4];
  int n_fail = 0, total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ts <= ts + 64'h1;
  always @(posedge ref_clk)
    if (memValid && memReady && memWrite && memAddr[31:12] == 20'h2)
      rec[memAddr[4:3]] <= memWdata;
  tpr_thread_profiler tpr_thread_profiler_i (.ref_clk, .rst, .awaddr,
    .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .retireValid, .retireEvents, .retireAddr(ts),
    .retireData(~ts), .currentPrivilegeLevel(priv),
    .retireFromLower(fromLower), .systemManagementState(mgmt),
    .perfTimestampCounter(ts), .recDiscard(discard), .memValid, .memWrite,
    .memAddr, .memWdata, .memReady, .memRdata, .thresholdIrq);
  tpr_mem_model tpr_mem_model_i (.ref_clk, .rst, .memValid, .memWrite,
    .tailIdx, .slow, .memReady, .memRdata);
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    resp = bresp; bready <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rdv = rdata; resp = rresp; rready <= 0;
    @(posedge ref_clk);
  endtask
  // one retire, then optionally wait until the engine is idle
  task automatic ret(input logic [3:0] ev, input logic [1:0] pl, bit w);
    retireValid <= 1; retireEvents <= ev; priv <= pl;
    @(posedge ref_clk);
    retireValid <= 0;
    if (!w) @(posedge ref_clk);
    else do rd(tpr_pkg::ADDR_STATUS); while (rdv[tpr_pkg::STAT_BUSY]);
  endtask
  task automatic hm(input logic [31:0] h, input logic [31:0] m);
    rd(tpr_pkg::ADDR_HEAD); chk(rdv, h);
    rd(tpr_pkg::ADDR_MISS_LO); chk(rdv, m);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    rd(tpr_pkg::ADDR_BUF_SIZE); chk(rdv, 32'h0000_0100);
    chk(resp, tpr_pkg::RESP_OKAY);
    rd(tpr_pkg::ADDR_CAP); chk(rdv[0], 1'b1);
    wr(8'h2C, 32'h0000_0010); rd(8'h2C); chk(rdv, 32'h0000_0040);
    wr(8'h40, 32'h0); chk(resp, tpr_pkg::RESP_SLVERR);
    rd(8'h40); chk(resp, tpr_pkg::RESP_SLVERR);
    $display("test_regs done");
  endtask
  task automatic test_sync;
    wr(tpr_pkg::ADDR_CB_BASE, 32'h0000_1000);
    wr(tpr_pkg::ADDR_BUF_BASE, 32'h0000_2000);
    wr(tpr_pkg::ADDR_BUF_SIZE, 32'h0000_0004);
    wr(tpr_pkg::ADDR_THRESH, 32'h0000_0002);
    wr(tpr_pkg::ADDR_INTV0, 32'h0000_0001);
    wr(tpr_pkg::ADDR_CTRL, 32'h0000_0009);
    repeat (8) ret(4'h1, 2'h3, 1);
    hm(32'h3, 32'h1);
    chk(rec[0][7:0], 8'h01);
    chk(rec[3], 64'h0);
    chk(thresholdIrq, 1'b1);
    tailIdx <= 16'h2;
    repeat (2) ret(4'h1, 2'h3, 1);
    hm(32'h0, 32'h1);
    wr(tpr_pkg::ADDR_STATUS, 32'h1); chk(thresholdIrq, 1'b0);
    $display("test_sync done");
  endtask
  task automatic test_wrap;
    slow <= 4'h3;
    wr(tpr_pkg::ADDR_CTRL, 32'h0); tailIdx <= 16'h0;
    wr(tpr_pkg::ADDR_CTRL, 32'h0000_0007);
    repeat (8) ret(4'h1, 2'h3, 1);
    hm(32'h0, 32'h1);
    chk(rec[3], rec[1]);
    chk(rec[2], ~rec[1]);
    ret(4'h1, 2'h3, 1); ret(4'h1, 2'h2, 1);
    fromLower <= 1; ret(4'h1, 2'h3, 1); fromLower <= 0;
    mgmt <= 1; ret(4'h1, 2'h3, 1); mgmt <= 0;
    hm(32'h0, 32'h1);
    ret(4'h1, 2'h3, 0); ret(4'h1, 2'h3, 1);
    hm(32'h1, 32'h1);
    ret(4'h1, 2'h3, 1);
    hm(32'h2, 32'h1);
    $display("test_wrap done");
  endtask
  task automatic test_discard;
    ret(4'h1, 2'h3, 1);
    retireValid <= 1; @(posedge ref_clk);
    retireValid <= 0; discard <= 1; @(posedge ref_clk);
    discard <= 0;
    hm(32'h2, 32'h1);
    ret(4'h1, 2'h3, 1);
    hm(32'h3, 32'h1);
    wr(tpr_pkg::ADDR_CTRL, 32'h0); hm(32'h3, 32'h1);
    $display("test_discard done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    test_regs;
    test_sync;
    test_wrap;
    test_discard;
    report_and_stop;
  end
  initial begin
    #1_000_000;
    n_fail++;
    report_and_stop;
  end
endmodule

// ### dv/tpr_mem_model.sv
// far-side memory: accepts profiler requests, serves the tail word
// assumes one request at a time, held until memReady
`timescale 1ns/1ps
module tpr_mem_model (
  input  wire logic        ref_clk,  // clock
  input  wire logic        rst,      // async reset
  input  wire logic        memValid, // request
  input  wire logic        memWrite, // 1 write
  input  wire logic [15:0] tailIdx,  // tail record index
  input  wire logic [3:0]  slow,     // wait cycles
  output logic             memReady, // accept pulse
  output logic [63:0]      memRdata  // read data
);
  logic [3:0] waitCnt;
  // never writes head, only reports the tail it is given
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memReady <= 1'b0;
      waitCnt  <= 4'h0;
    end else if (memValid && !memReady && waitCnt >= slow) begin
      memReady <= 1'b1;
      waitCnt  <= 4'h0;
    end else begin
      memReady <= 1'b0;
      waitCnt  <= waitCnt + {3'h0, memValid && !memReady};
    end
  end
  // outside an answer the data lines show junk
  assign memRdata = (memReady && !memWrite) ? {48'h0, tailIdx}
                                            : ~{48'h0, tailIdx};
endmodule

// ### dv/tpr_thread_profiler_assertions.sv
// port checker for the profiler engine
// assumes bind into tpr_thread_profiler, control block at 0x1000
`timescale 1ns/1ps
module tpr_thread_profiler_assertions #(
  parameter logic [31:0] TAIL_ADDR = 32'h0000_1008
) (
  input wire logic        ref_clk, rst, awvalid, awready, wvalid,
  input wire logic        wready, bvalid, bready, arvalid, arready,
  input wire logic        rvalid, rready, memValid, memReady, memWrite,
  input wire logic [1:0]  bresp, rresp,
  input wire logic [31:0] rdata, memAddr,
  input wire logic [63:0] memWdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  chk_b_follows: assert property
    (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("no write response");
  chk_r_follows: assert property (arvalid && arready |=> rvalid)
    else $error("no read data");
  chk_ready_low: assert property (bvalid |-> !awready && !wready)
    else $error("ready while response pending");
  chk_mem_hold: assert property (memValid && !memReady |=>
    memValid && $stable(memAddr) && $stable(memWdata))
    else $error("memory request changed");
  chk_mem_drop: assert property (memValid && memReady |=> !memValid)
    else $error("memory request not released");
  chk_tail_ro: assert property (memValid && memWrite |->
    memAddr != TAIL_ADDR)
    else $error("tail pointer written");
  cover property (memValid && memReady && memWrite);
  cover property (memValid && memReady && !memWrite);
  cover property (bvalid && bresp == tpr_pkg::RESP_SLVERR);
endmodule
bind tpr_thread_profiler tpr_thread_profiler_assertions chk_i (.*);

// ### verilog/tpr_thread_profiler.sv
// per-thread profiling engine: event counters, record store to a
// memory ring buffer, missed-record count, threshold interrupt.
// assumes: one clock, retire inputs synchronous, memory port that
// holds memReady high for one cycle per accepted request.
`timescale 1ns/1ps

// Operation
// - sync mode: full buffer keeps head, bumps missed count
// - wrap mode: full buffer still stored, head advances, missed bumped
// - sync mode resumes storing once the tail moves on
// - each qualifying retired instruction decrements every counter it hits
// - negative counter gathers a record, timestamp if enabled, keeps counting
// - several negative counters: pick one, others wait and retry later
// - discarded occurrence: next instruction causing that event is taken
// - complete record written at head, then head advances
// - full when next head equals tail; 64-bit missed count incremented
// - only one record stored at a time, others retried later
// - store, report and reload may lag retirement, data stay exact
// - occupancy above threshold with interrupts enabled raises interrupt
// - after store or miss, reload counter from interval, optional random
// - overrun below -1 is subtracted from the reload value
// - intervals except value sample clamped to a minimum, readable back
// - tail never written, application region never overwritten in sync
// - suspected full or threshold rereads tail from memory first
// - capability register reports wrap mode support
// - count only user-level retires, not entries to it, not in mgmt state
module tpr_thread_profiler #(
  parameter logic [7:0] CORE_ID = 8'h00  // arbitrary value
) (
  input  wire logic                      ref_clk,          // core clock
  input  wire logic                      rst,              // async reset
  input  wire logic [7:0]                awaddr,           // axi write addr
  input  wire logic                      awvalid,          // axi
  output logic                           awready,          // axi
  input  wire logic [31:0]               wdata,            // axi
  input  wire logic [3:0]                wstrb,            // axi
  input  wire logic                      wvalid,           // axi
  output logic                           wready,           // axi
  output logic [1:0]                     bresp,            // axi
  output logic                           bvalid,           // axi
  input  wire logic                      bready,           // axi
  input  wire logic [7:0]                araddr,           // axi read addr
  input  wire logic                      arvalid,          // axi
  output logic                           arready,          // axi
  output logic [31:0]                    rdata,            // axi
  output logic [1:0]                     rresp,            // axi
  output logic                           rvalid,           // axi
  input  wire logic                      rready,           // axi
  input  wire logic                      retireValid,      // insn retires
  input  wire logic [tpr_pkg::NUM_EV-1:0] retireEvents,    // events caused
  input  wire logic [63:0]               retireAddr,       // insn address
  input  wire logic [63:0]               retireData,       // sample operand
  input  wire logic [1:0]                currentPrivilegeLevel, // priv
  input  wire logic                      retireFromLower,  // enters user
  input  wire logic                      systemManagementState, // mgmt
  input  wire logic [63:0]               perfTimestampCounter, // timestamp
  input  wire logic                      recDiscard,       // drop pending
  output logic                           memValid,         // mem request
  output logic                           memWrite,         // 1 write
  output logic [31:0]                    memAddr,          // byte address
  output logic [63:0]                    memWdata,         // write data
  input  wire logic                      memReady,         // accepted
  input  wire logic [63:0]               memRdata,         // read data
  output logic                           thresholdIrq      // level irq
);

  typedef enum {
    S_IDLE, S_CHECK, S_TAIL, S_REC, S_HEAD, S_MISS, S_RELOAD, S_RPT
  } tpr_state_e;

  tpr_state_e         state;
  logic [31:0]        ctrlReg;
  logic [31:0]        cbBase;
  logic [31:0]        bufBase;
  logic [15:0]        bufSize;
  logic [15:0]        thresh;
  logic [31:0]        intv [tpr_pkg::NUM_EV];
  logic signed [31:0] cnt [tpr_pkg::NUM_EV];
  logic               startPulse;
  logic               irqClr;
  logic               contMode;
  logic               tsMode;
  logic [15:0]        head;
  logic [15:0]        tailCache;
  logic               tailFresh;
  logic [63:0]        missed;
  logic [1:0]         selIdx;
  logic [63:0]        recAddr;
  logic [63:0]        recData;
  logic [63:0]        recTs;
  logic               doMiss;
  logic               rptCheck;
  logic [1:0]         beat;
  logic [15:0]        lfsr;
  logic               awGot;
  logic               wGot;
  logic [7:0]         awAddrQ;
  logic [31:0]        wDataQ;
  logic [3:0]         wStrbQ;

  logic               running;
  logic               elig;
  logic               pickHit;
  logic [1:0]         pickIdx;
  logic [15:0]        nextHead;
  logic               bufFull;
  logic [15:0]        occupancy;
  logic               reloadEn;
  logic signed [31:0] reloadVal;
  logic [31:0]        readVal;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a < tpr_pkg::ADDR_INTV_END);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  s);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = s[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    merge = old;
  endfunction

  assign running  = ctrlReg[tpr_pkg::CTRL_EN];
  assign elig     = retireValid && running
                    && (currentPrivilegeLevel == tpr_pkg::USER_PRIV)
                    && !retireFromLower && !systemManagementState;
  assign nextHead = (head == bufSize - 16'h1) ? 16'h0 : head + 16'h1;
  assign bufFull  = (nextHead == tailCache);
  assign occupancy = (head >= tailCache) ? head - tailCache
                                         : head + bufSize - tailCache;
  assign reloadEn = (state == S_RELOAD);

  // lowest counter that goes negative with this instruction
  always_comb begin
    pickHit = 1'b0;
    pickIdx = 2'h0;
    for (int i = tpr_pkg::NUM_EV - 1; i >= 0; i--) begin
      if (elig && retireEvents[i] && cnt[i] <= 32'sd0) begin
        pickHit = 1'b1;
        pickIdx = 2'(i);
      end
    end
  end

  // reload from interval less any overrun past -1
  always_comb begin
    logic signed [31:0] nc;
    logic [31:0]        base;
    nc   = cnt[selIdx] - ((elig && retireEvents[selIdx]) ? 32'sd1 : 32'sd0);
    base = intv[selIdx];
    if (ctrlReg[tpr_pkg::CTRL_RAND]) begin
      base[tpr_pkg::RAND_BITS-1:0] = base[tpr_pkg::RAND_BITS-1:0]
                                     ^ lfsr[tpr_pkg::RAND_BITS-1:0];
    end
    reloadVal = $signed(base);
    if (nc < -32'sd1) begin
      reloadVal = $signed(base) - (-32'sd1 - nc);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event counters

  for (genvar g = 0; g < tpr_pkg::NUM_EV; g++) begin : g_cnt
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        cnt[g] <= $signed(tpr_pkg::INTV_RESET);
      end else if (startPulse) begin
        cnt[g] <= $signed(intv[g]);
      end else if (reloadEn && selIdx == 2'(g)) begin
        cnt[g] <= reloadVal;
      end else if (elig && retireEvents[g]) begin
        cnt[g] <= cnt[g] - 32'sd1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lfsr <= tpr_pkg::LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gather, store, report sequencer and memory port

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state        <= S_IDLE;
      memValid     <= 1'b0;
      memWrite     <= 1'b0;
      memAddr      <= 32'h0;
      memWdata     <= 64'h0;
      contMode     <= 1'b0;
      tsMode       <= 1'b0;
      head         <= 16'h0;
      tailCache    <= 16'h0;
      tailFresh    <= 1'b0;
      missed       <= 64'h0;
      selIdx       <= 2'h0;
      recAddr      <= 64'h0;
      recData      <= 64'h0;
      recTs        <= 64'h0;
      doMiss       <= 1'b0;
      rptCheck     <= 1'b0;
      beat         <= 2'h0;
      thresholdIrq <= 1'b0;
    end else begin
      if (irqClr) begin
        thresholdIrq <= 1'b0;
      end
      unique case (state)
        S_IDLE: begin
          tailFresh <= 1'b0;
          if (startPulse) begin
            contMode  <= ctrlReg[tpr_pkg::CTRL_CONT];
            tsMode    <= ctrlReg[tpr_pkg::CTRL_TS];
            head      <= 16'h0;
            tailCache <= 16'h0;
            missed    <= 64'h0;
          end else if (pickHit) begin
            selIdx  <= pickIdx;
            recAddr <= retireAddr;
            recData <= (pickIdx == 2'(tpr_pkg::VALUE_EV)) ? retireData
                                                          : 64'h0;
            recTs   <= tsMode ? perfTimestampCounter : 64'h0;
            state   <= S_CHECK;
          end
        end
        S_CHECK: begin
          doMiss <= 1'b0;
          beat   <= 2'h0;
          if (recDiscard) begin
            state <= S_IDLE;
          end else if (bufFull && !tailFresh) begin
            rptCheck <= 1'b0;
            state    <= S_TAIL;
          end else if (bufFull && !contMode) begin
            missed <= missed + 64'h1;
            doMiss <= 1'b1;
            state  <= S_MISS;
          end else if (bufFull) begin
            missed <= missed + 64'h1;
            doMiss <= 1'b1;
            state  <= S_REC;
          end else begin
            state <= S_REC;
          end
        end
        S_TAIL: begin
          if (!memValid) begin
            memValid <= 1'b1;
            memWrite <= 1'b0;
            memAddr  <= cbBase + tpr_pkg::CB_TAIL_OFS;
          end else if (memReady) begin
            memValid  <= 1'b0;
            tailCache <= memRdata[15:0];
            tailFresh <= 1'b1;
            state     <= rptCheck ? S_RPT : S_CHECK;
          end
        end
        S_REC: begin
          if (!memValid) begin
            memValid <= 1'b1;
            memWrite <= 1'b1;
            memAddr  <= bufBase + {11'h0, head, 5'h0}
                        + {27'h0, beat, 3'h0};
            unique case (beat)
              2'h0: memWdata <= {32'h0, 16'h0, CORE_ID,
                                 tpr_pkg::EV_ID[selIdx]};
              2'h1: memWdata <= recAddr;
              2'h2: memWdata <= recData;
              2'h3: memWdata <= recTs;
            endcase
          end else if (memReady) begin
            memValid <= 1'b0;
            beat     <= beat + 2'h1;
            if (beat == tpr_pkg::LAST_BEAT) begin
              head  <= nextHead;
              state <= S_HEAD;
            end
          end
        end
        S_HEAD: begin
          if (!memValid) begin
            memValid <= 1'b1;
            memWrite <= 1'b1;
            memAddr  <= cbBase + tpr_pkg::CB_HEAD_OFS;
            memWdata <= {48'h0, head};
          end else if (memReady) begin
            memValid <= 1'b0;
            state    <= doMiss ? S_MISS : S_RELOAD;
          end
        end
        S_MISS: begin
          if (!memValid) begin
            memValid <= 1'b1;
            memWrite <= 1'b1;
            memAddr  <= cbBase + tpr_pkg::CB_MISS_OFS;
            memWdata <= missed;
          end else if (memReady) begin
            memValid <= 1'b0;
            state    <= S_RELOAD;
          end
        end
        S_RELOAD: begin
          state <= S_RPT;
        end
        S_RPT: begin
          if (ctrlReg[tpr_pkg::CTRL_IRQ] && occupancy > thresh) begin
            if (!tailFresh) begin
              rptCheck <= 1'b1;
              state    <= S_TAIL;
            end else begin
              thresholdIrq <= 1'b1;
              state        <= S_IDLE;
            end
          end else begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register write channel

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awGot      <= 1'b0;
      wGot       <= 1'b0;
      awAddrQ    <= 8'h0;
      wDataQ     <= 32'h0;
      wStrbQ     <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= tpr_pkg::RESP_OKAY;
      ctrlReg    <= tpr_pkg::CTRL_RESET;
      cbBase     <= tpr_pkg::BASE_RESET;
      bufBase    <= tpr_pkg::BASE_RESET;
      bufSize    <= tpr_pkg::BUF_SIZE_RESET;
      thresh     <= tpr_pkg::THRESH_RESET;
      startPulse <= 1'b0;
      irqClr     <= 1'b0;
      for (int i = 0; i < tpr_pkg::NUM_EV; i++) begin
        intv[i] <= tpr_pkg::INTV_RESET;
      end
    end else begin
      startPulse <= 1'b0;
      irqClr     <= 1'b0;
      if (awvalid && awready) begin
        awGot   <= 1'b1;
        awready <= 1'b0;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wGot   <= 1'b1;
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (awGot && wGot && !bvalid) begin
        bvalid <= 1'b1;
        bresp  <= isMapped(awAddrQ) ? tpr_pkg::RESP_OKAY
                                    : tpr_pkg::RESP_SLVERR;
        unique case (awAddrQ)
          tpr_pkg::ADDR_CTRL: begin
            ctrlReg <= merge(ctrlReg, wDataQ, wStrbQ);
            startPulse <= (wStrbQ[0] ? wDataQ[tpr_pkg::CTRL_EN]
                                     : ctrlReg[tpr_pkg::CTRL_EN])
                          && !ctrlReg[tpr_pkg::CTRL_EN];
          end
          tpr_pkg::ADDR_CB_BASE:  cbBase  <= merge(cbBase, wDataQ, wStrbQ);
          tpr_pkg::ADDR_BUF_BASE: bufBase <= merge(bufBase, wDataQ, wStrbQ);
          tpr_pkg::ADDR_BUF_SIZE:
            bufSize <= 16'(merge({16'h0, bufSize}, wDataQ, wStrbQ));
          tpr_pkg::ADDR_THRESH:
            thresh <= 16'(merge({16'h0, thresh}, wDataQ, wStrbQ));
          tpr_pkg::ADDR_STATUS:
            irqClr <= wStrbQ[0] && wDataQ[tpr_pkg::STAT_IRQ];
          default: begin
            for (int i = 0; i < tpr_pkg::NUM_EV; i++) begin
              if (awAddrQ == tpr_pkg::ADDR_INTV0 + 8'(i * 4)) begin
                if (i != tpr_pkg::VALUE_EV
                    && merge(intv[i], wDataQ, wStrbQ) < tpr_pkg::RELOAD_MIN)
                begin
                  intv[i] <= tpr_pkg::RELOAD_MIN;
                end else begin
                  intv[i] <= merge(intv[i], wDataQ, wStrbQ);
                end
              end
            end
          end
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awGot   <= 1'b0;
        wGot    <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read channel

  always_comb begin
    readVal = 32'h0;
    unique case (araddr)
      tpr_pkg::ADDR_CTRL:     readVal = ctrlReg;
      tpr_pkg::ADDR_CAP:      readVal[tpr_pkg::CAP_WRAP] =
                                tpr_pkg::WRAP_SUPPORTED;
      tpr_pkg::ADDR_CB_BASE:  readVal = cbBase;
      tpr_pkg::ADDR_BUF_BASE: readVal = bufBase;
      tpr_pkg::ADDR_BUF_SIZE: readVal = {16'h0, bufSize};
      tpr_pkg::ADDR_THRESH:   readVal = {16'h0, thresh};
      tpr_pkg::ADDR_HEAD:     readVal = {16'h0, head};
      tpr_pkg::ADDR_MISS_LO:  readVal = missed[31:0];
      tpr_pkg::ADDR_MISS_HI:  readVal = missed[63:32];
      tpr_pkg::ADDR_STATUS: begin
        readVal[tpr_pkg::STAT_IRQ]  = thresholdIrq;
        readVal[tpr_pkg::STAT_BUSY] = (state != S_IDLE);
        readVal[tpr_pkg::STAT_RUN]  = running;
      end
      default: begin
        for (int i = 0; i < tpr_pkg::NUM_EV; i++) begin
          if (araddr == tpr_pkg::ADDR_INTV0 + 8'(i * 4)) begin
            readVal = intv[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= tpr_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= readVal;
        rresp   <= isMapped(araddr) ? tpr_pkg::RESP_OKAY
                                    : tpr_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule
